// File: rtl/mae_pkg.sv
// constants shared by the multiply-accumulate engine files
package mae_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_ACC_BYTE_ZERO   = 8'h93;
  localparam logic [7:0] ADDR_ACC_BYTE_ONE    = 8'h94;
  localparam logic [7:0] ADDR_ACC_BYTE_TWO    = 8'h95;
  localparam logic [7:0] ADDR_ACC_BYTE_THREE  = 8'h96;
  localparam logic [7:0] ADDR_ACC_TOP_BYTE    = 8'h97;
  localparam logic [7:0] ADDR_ENGINE_FLAGS    = 8'hc0;
  localparam logic [7:0] ADDR_OPERAND_A_LOW   = 8'hc1;
  localparam logic [7:0] ADDR_OPERAND_A_HIGH  = 8'hc2;
  localparam logic [7:0] ADDR_ENGINE_CONFIG   = 8'hc3;
  localparam logic [7:0] ADDR_OPERAND_B_LOW   = 8'hc4;
  localparam logic [7:0] ADDR_OPERAND_B_HIGH  = 8'hc5;
  localparam logic [7:0] ADDR_ROUNDED_HIGH    = 8'hcf;
  localparam logic [7:0] ADDR_ROUNDED_LOW     = 8'hce;

  // engine_config field positions
  localparam int CFG_SHIFT_GO      = 5;
  localparam int CFG_SHIFT_DIR     = 4;
  localparam int CFG_CLEAR_ACC     = 3;
  localparam int CFG_SATURATE      = 2;
  localparam int CFG_FRACTIONAL    = 1;
  localparam int CFG_MULTIPLY_ONLY = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3f;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  // engine_flags field positions
  localparam int FLG_HARD_OVF = 3;
  localparam int FLG_ZERO     = 2;
  localparam int FLG_SOFT_OVF = 1;
  localparam int FLG_NEGATIVE = 0;
  localparam logic [3:0] FLG_RESET = 4'h4;

  // accumulator top-byte crossing values
  localparam logic [7:0] TOP_POS_LIMIT = 8'h7f;
  localparam logic [7:0] TOP_NEG_LIMIT = 8'h80;

  // rounding constants
  localparam logic [15:0] RND_HALF    = 16'h8000;
  localparam logic [15:0] RND_SAT_POS = 16'h7fff;
  localparam logic [15:0] RND_SAT_NEG = 16'h8000;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// File: rtl/mae_multiplier.sv
// first pipeline stage: registered signed 16x16 product
`timescale 1ns/1ps
`default_nettype none
module mae_multiplier #(
  parameter int OP_WIDTH = 16
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    start,
  input  wire logic                    fractional,
  input  wire logic [OP_WIDTH-1:0]     op_a,
  input  wire logic [OP_WIDTH-1:0]     op_b,
  output logic      [2*OP_WIDTH:0]     product_q,
  output logic                         valid_q
);

  // the accumulator alignment below assumes sixteen-bit operands
  if (OP_WIDTH != 16)
  begin : g_width_check
    $error("mae_multiplier supports OP_WIDTH of 16 only");
  end

  logic signed [2*OP_WIDTH-1:0] raw_prod;
  assign raw_prod = $signed(op_a) * $signed(op_b);

  // fractional products are shifted so the point sits between bits 31 and 30
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      product_q <= '0;
    end
    else if (start)
    begin
      if (fractional)
        product_q <= {raw_prod, 1'b0};
      else
        product_q <= {raw_prod[2*OP_WIDTH-1], raw_prod};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      valid_q <= 1'b0;
    else
      valid_q <= start;
  end

endmodule
`default_nettype wire

// File: rtl/mae_rounder.sv
// third pipeline stage: unbiased rounding with optional saturation
`timescale 1ns/1ps
`default_nettype none
module mae_rounder (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        update,
  input  wire logic        saturate,
  input  wire logic        soft_ovf,
  input  wire logic [39:0] acc,
  output logic      [15:0] rounded_q
);

  logic        round_up;
  logic [16:0] sum;
  logic [15:0] result;

  always_comb
  begin
    round_up = (acc[15:0] > mae_pkg::RND_HALF) ||
               ((acc[15:0] == mae_pkg::RND_HALF) && acc[16]);
    sum = {1'b0, acc[31:16]} + {16'h0000, round_up};
    result = sum[15:0];
    // saturate when the accumulator is out of 16-bit range or rounding wrapped
    if (saturate && (soft_ovf || (round_up && acc[31:16] == mae_pkg::RND_SAT_POS)))
      result = acc[39] ? mae_pkg::RND_SAT_NEG : mae_pkg::RND_SAT_POS;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rounded_q <= '0;
    else if (update)
      rounded_q <= result;
  end

endmodule
`default_nettype wire

// File: rtl/mae_engine.sv
// 16x16 signed multiply-accumulate engine with 40-bit accumulator and sfr port
`timescale 1ns/1ps
`default_nettype none
module mae_engine (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata_q
);

  logic [5:0]  config_q;
  logic [3:0]  flags_q;
  logic [15:0] op_a_q;
  logic [15:0] op_b_q;
  logic [39:0] acc_q;
  logic        round_go_q;
  logic [32:0] product;
  logic        product_valid;
  logic [15:0] rounded;
  logic        start;
  logic        start_q;
  logic        wr_config;
  logic        wr_flags;
  logic        wr_acc0;
  logic        wr_acc_any;
  logic        do_clear;
  logic        do_shift;
  logic [39:0] acc_sum;
  logic [39:0] acc_shifted;

  assign start      = sfr_wr && (sfr_addr == mae_pkg::ADDR_OPERAND_B_LOW);
  assign wr_config  = sfr_wr && (sfr_addr == mae_pkg::ADDR_ENGINE_CONFIG);
  assign wr_flags   = sfr_wr && (sfr_addr == mae_pkg::ADDR_ENGINE_FLAGS);
  assign wr_acc0    = sfr_wr && (sfr_addr == mae_pkg::ADDR_ACC_BYTE_ZERO);
  assign wr_acc_any = sfr_wr && (sfr_addr >= mae_pkg::ADDR_ACC_BYTE_ZERO) &&
                      (sfr_addr <= mae_pkg::ADDR_ACC_TOP_BYTE);
  assign do_clear   = config_q[mae_pkg::CFG_CLEAR_ACC];
  assign do_shift   = config_q[mae_pkg::CFG_SHIFT_GO] && !do_clear;

  // operand b low byte lands on the same edge as the strobe, so the multiply waits one cycle for it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      start_q <= 1'b0;
    else
      start_q <= start;
  end

  // stage one: multiply
  mae_multiplier #(
    .OP_WIDTH (16)
  ) u_mult (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (start_q),
    .fractional (config_q[mae_pkg::CFG_FRACTIONAL]),
    .op_a       (op_a_q),
    .op_b       (op_b_q),
    .product_q  (product),
    .valid_q    (product_valid)
  );

  // stage two sum: multiply-only adds to zero
  always_comb
  begin
    if (config_q[mae_pkg::CFG_MULTIPLY_ONLY])
      acc_sum = {{7{product[32]}}, product};
    else
      acc_sum = acc_q + {{7{product[32]}}, product};
  end

  // arithmetic shift by one; right keeps bit 39
  always_comb
  begin
    if (config_q[mae_pkg::CFG_SHIFT_DIR])
      acc_shifted = {acc_q[39], acc_q[39:1]};
    else
      acc_shifted = {acc_q[38:0], 1'b0};
  end

  // operand registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      op_a_q <= '0;
      op_b_q <= '0;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr)
        mae_pkg::ADDR_OPERAND_A_LOW:  op_a_q[7:0]  <= sfr_wdata;
        mae_pkg::ADDR_OPERAND_A_HIGH: op_a_q[15:8] <= sfr_wdata;
        mae_pkg::ADDR_OPERAND_B_LOW:  op_b_q[7:0]  <= sfr_wdata;
        mae_pkg::ADDR_OPERAND_B_HIGH: op_b_q[15:8] <= sfr_wdata;
        default:                      op_a_q       <= op_a_q;
      endcase
    end
  end

  // configuration; action bits self-clear after one cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      config_q <= mae_pkg::CFG_RESET[5:0];
    else if (wr_config)
      config_q <= sfr_wdata[5:0] & mae_pkg::CFG_WRITE_MASK[5:0];
    else
    begin
      config_q[mae_pkg::CFG_SHIFT_GO]  <= 1'b0;
      config_q[mae_pkg::CFG_CLEAR_ACC] <= 1'b0;
    end
  end

  // accumulator: clear, shift, stage two result, or byte write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc_q <= '0;
    else if (do_clear)
      acc_q <= '0;
    else if (do_shift)
      acc_q <= acc_shifted;
    else if (product_valid)
      acc_q <= acc_sum;
    else if (wr_acc_any)
    begin
      case (sfr_addr)
        mae_pkg::ADDR_ACC_BYTE_ZERO:  acc_q[7:0]   <= sfr_wdata;
        mae_pkg::ADDR_ACC_BYTE_ONE:   acc_q[15:8]  <= sfr_wdata;
        mae_pkg::ADDR_ACC_BYTE_TWO:   acc_q[23:16] <= sfr_wdata;
        mae_pkg::ADDR_ACC_BYTE_THREE: acc_q[31:24] <= sfr_wdata;
        default:                      acc_q[39:32] <= sfr_wdata;
      endcase
    end
  end

  // status flags, set at the end of stage two; shifts leave them alone
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags_q <= mae_pkg::FLG_RESET;
    else if (do_clear)
      flags_q <= mae_pkg::FLG_RESET;
    else if (product_valid && !do_shift)
    begin
      flags_q[mae_pkg::FLG_ZERO]     <= (acc_sum == 40'h00_0000_0000);
      flags_q[mae_pkg::FLG_NEGATIVE] <= acc_sum[39];
      // soft overflow: bits 39..31 not all equal
      flags_q[mae_pkg::FLG_SOFT_OVF] <= !((&acc_sum[39:31]) || !(|acc_sum[39:31]));
      // sticky; multiply-only leaves it alone
      if (!config_q[mae_pkg::CFG_MULTIPLY_ONLY] &&
          (((acc_q[39:32] == mae_pkg::TOP_POS_LIMIT) && (acc_sum[39:32] == mae_pkg::TOP_NEG_LIMIT)) ||
           ((acc_q[39:32] == mae_pkg::TOP_NEG_LIMIT) && (acc_sum[39:32] == mae_pkg::TOP_POS_LIMIT))))
        flags_q[mae_pkg::FLG_HARD_OVF] <= 1'b1;
      else if (wr_flags)
        flags_q[mae_pkg::FLG_HARD_OVF] <= sfr_wdata[mae_pkg::FLG_HARD_OVF];
    end
    else if (wr_flags)
      flags_q <= sfr_wdata[3:0];
  end

  // rounding runs after stage two, after a shift or a clear, or after a byte-zero write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      round_go_q <= 1'b0;
    else
      round_go_q <= product_valid || do_shift || do_clear || wr_acc0;
  end

  // stage three: rounding
  mae_rounder u_round (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .update    (round_go_q),
    .saturate  (config_q[mae_pkg::CFG_SATURATE]),
    .soft_ovf  (flags_q[mae_pkg::FLG_SOFT_OVF] || !((&acc_q[39:31]) || !(|acc_q[39:31]))),
    .acc       (acc_q),
    .rounded_q (rounded)
  );

  // read port, registered; unmapped addresses read zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sfr_rdata_q <= mae_pkg::BYTE_ZERO;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        mae_pkg::ADDR_ACC_BYTE_ZERO:  sfr_rdata_q <= acc_q[7:0];
        mae_pkg::ADDR_ACC_BYTE_ONE:   sfr_rdata_q <= acc_q[15:8];
        mae_pkg::ADDR_ACC_BYTE_TWO:   sfr_rdata_q <= acc_q[23:16];
        mae_pkg::ADDR_ACC_BYTE_THREE: sfr_rdata_q <= acc_q[31:24];
        mae_pkg::ADDR_ACC_TOP_BYTE:   sfr_rdata_q <= acc_q[39:32];
        mae_pkg::ADDR_ENGINE_FLAGS:   sfr_rdata_q <= {4'h0, flags_q};
        mae_pkg::ADDR_ENGINE_CONFIG:  sfr_rdata_q <= {2'b00, config_q};
        mae_pkg::ADDR_OPERAND_A_LOW:  sfr_rdata_q <= op_a_q[7:0];
        mae_pkg::ADDR_OPERAND_A_HIGH: sfr_rdata_q <= op_a_q[15:8];
        mae_pkg::ADDR_OPERAND_B_LOW:  sfr_rdata_q <= op_b_q[7:0];
        mae_pkg::ADDR_OPERAND_B_HIGH: sfr_rdata_q <= op_b_q[15:8];
        mae_pkg::ADDR_ROUNDED_HIGH:   sfr_rdata_q <= rounded[15:8];
        mae_pkg::ADDR_ROUNDED_LOW:    sfr_rdata_q <= rounded[7:0];
        default:                      sfr_rdata_q <= mae_pkg::BYTE_ZERO;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: tb/mae_engine_chk.sv
// concurrent checks on the engine's special function register port
`timescale 1ns/1ps
`default_nettype none
module mae_engine_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_shift_go;
    sfr_wr && sfr_addr == 8'hc3 && sfr_wdata[5];
  endsequence
  sequence s_clear_go;
    sfr_wr && sfr_addr == 8'hc3 && sfr_wdata[3];
  endsequence
  sequence s_quiet;
    (!sfr_wr) [*3];
  endsequence
  a_cfg_upper_zero: assert property (sfr_rd && sfr_addr == 8'hc3 |=> sfr_rdata_q[7:6] == 2'h0)
    else $error("config upper bits not zero");
  a_flag_upper_zero: assert property (sfr_rd && sfr_addr == 8'hc0 |=> sfr_rdata_q[7:4] == 4'h0)
    else $error("flag upper bits not zero");
  a_unmapped_reads_zero: assert property (sfr_rd && !(sfr_addr inside {[8'h93:8'h97], [8'hc0:8'hc5], 8'hce, 8'hcf})
    |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
    else $error("read data moved without a read");
  a_shift_self_clear: assert property (s_shift_go ##1 s_quiet ##1 (sfr_rd && sfr_addr == 8'hc3) |=> !sfr_rdata_q[5])
    else $error("shift bit still set");
  a_clear_self_clear: assert property (s_clear_go ##1 s_quiet ##1 (sfr_rd && sfr_addr == 8'hc3) |=> !sfr_rdata_q[3])
    else $error("clear bit still set");
  a_clear_resets_flags: assert property (s_clear_go ##1 s_quiet ##1 (sfr_rd && sfr_addr == 8'hc0) |=> sfr_rdata_q == 8'h04)
    else $error("flags not reset by clear");
  a_cfg_readback: assert property ((sfr_wr && sfr_addr == 8'hc3 && !sfr_wdata[5] && !sfr_wdata[3])
    ##1 (sfr_rd && sfr_addr == 8'hc3) |=> sfr_rdata_q == ($past(sfr_wdata, 2) & 8'h3f))
    else $error("config readback wrong");
endmodule
bind mae_engine mae_engine_chk mae_engine_chk_inst (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q));
`default_nettype wire

// File: tb/mae_sfr_host.sv
// processor-side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mae_sfr_host (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_rd,
  input  wire logic [7:0] sfr_rdata_q
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    #2;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    #2;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    @(posedge clk);
    @(negedge clk);
    d = sfr_rdata_q;
    @(posedge clk);
  endtask
  // idle bus lets pipeline stages finish before software touches the engine
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the multiply-accumulate engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk;
  logic       sys_rst;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic       sfr_rd;
  logic [7:0] sfr_rdata_q;
  int         err_total;
  int         check_count;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  mae_engine mae_engine_inst (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q));
  mae_sfr_host mae_sfr_host_inst (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH at %0t: read %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    mae_sfr_host_inst.put(a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    mae_sfr_host_inst.get(a, v);
    chk(v, e);
  endtask
  task automatic p(input int n);
    mae_sfr_host_inst.pause(n);
  endtask
  task automatic wacc(input logic [39:0] v);
    for (int i = 0; i < 5; i++)
      w(8'h93 + 8'(i), v[8*i +: 8]);
  endtask
  task automatic rcacc(input logic [39:0] e);
    for (int i = 0; i < 5; i++)
      rc(8'h93 + 8'(i), e[8*i +: 8]);
  endtask
  task automatic start(input logic [15:0] a, input logic [15:0] b);
    w(8'hc2, a[15:8]);
    w(8'hc1, a[7:0]);
    w(8'hc5, b[15:8]);
    w(8'hc4, b[7:0]);
    p(3);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    err_total = 0;
    check_count = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rc(8'hc3, 8'h00);
    rc(8'hc0, 8'h04);
    rcacc(40'h00_0000_0000);
    rc(8'hcf, 8'h00);
    rc(8'h80, 8'h00);
    w(8'hc3, 8'hc6);
    rc(8'hc3, 8'h06);
    w(8'hc0, 8'hf5);
    rc(8'hc0, 8'h05);
    w(8'hcf, 8'h12);
    rc(8'hcf, 8'h00);
    $display("test registers done");
    w(8'hc3, 8'h0a);
    p(3);
    rc(8'hc0, 8'h04);
    w(8'hc2, 8'h40);
    w(8'hc1, 8'h00);
    w(8'hc5, 8'h20);
    w(8'hc4, 8'h00);
    start(16'h4000, 16'he000);
    rcacc(40'h00_0000_0000);
    rc(8'hc0, 8'h04);
    start(16'h4000, 16'h2000);
    rc(8'h96, 8'h10);
    rc(8'hc0, 8'h00);
    rc(8'hcf, 8'h10);
    $display("test accumulate done");
    w(8'hc3, 8'h01);
    start(16'h1234, 16'hfedc);
    rcacc(40'hff_ffeb_3cb0);
    rc(8'hc0, 8'h01);
    rc(8'hcf, 8'hff);
    rc(8'hce, 8'heb);
    $display("test multiply only done");
    wacc(40'h40_8844_2211);
    w(8'hc3, 8'h20);
    p(3);
    rc(8'hc3, 8'h00);
    rcacc(40'h81_1088_4422);
    rc(8'hc0, 8'h01);
    w(8'hc3, 8'h30);
    p(3);
    w(8'hc3, 8'h30);
    p(3);
    rcacc(40'he0_4422_1108);
    rc(8'hcf, 8'h44);
    rc(8'hce, 8'h22);
    $display("test shift done");
    w(8'hc3, 8'h08);
    p(3);
    rc(8'hc3, 8'h00);
    wacc(40'h7f_ffff_ffff);
    w(8'hc3, 8'h04);
    start(16'h0001, 16'h0001);
    rcacc(40'h80_0000_0000);
    rc(8'hc0, 8'h0b);
    rc(8'hcf, 8'h80);
    rc(8'hce, 8'h00);
    start(16'h0001, 16'hffff);
    rc(8'h97, 8'h7f);
    rc(8'hc0, 8'h0a);
    rc(8'hcf, 8'h7f);
    rc(8'hce, 8'hff);
    start(16'h0001, 16'h0000);
    rc(8'hc0, 8'h0a);
    w(8'h97, 8'h00);
    w(8'h96, 8'h00);
    start(16'h0001, 16'h0001);
    rc(8'hc0, 8'h08);
    w(8'hc0, 8'h00);
    rc(8'hc0, 8'h00);
    $display("test overflow done");
    w(8'h94, 8'h80);
    w(8'h93, 8'h01);
    p(2);
    rc(8'hce, 8'h01);
    w(8'h93, 8'h00);
    p(2);
    rc(8'hce, 8'h00);
    w(8'h95, 8'h03);
    w(8'h93, 8'h00);
    p(2);
    rc(8'hce, 8'h04);
    $display("test rounding done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
